// *** dv/asc_ctrl_regs_props.sv ***
// Checker for the audio status and control register bank.
// Sees only top-level ports; bound from the bench top file.
`timescale 1ns/1ps
`default_nettype none
module asc_ctrl_regs_props (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    // Bus
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [17:0] wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // Receiver
    input wire logic        rx_bad_smp_stb,
    input wire logic        rx_frame_clk_in,
    input wire logic        rx_frame_clk_out,
    input wire logic [1:0]  rx_word_len_sel
);
    // =========================================================
    // Policy shadow, written with the design; the clock lags a cycle
    logic        pol_ff;
    logic        wr_ctrl;
    logic        req;
    logic [15:0] idx;
    assign idx = wb_adr_i[17:2];
    assign req = wb_cyc_i && wb_stb_i;
    assign wr_ctrl = wb_ack_o && wb_we_i && wb_sel_i[0]
        && (idx == asc_pkg::RX_CTRL_IDX);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pol_ff <= 1'b0;
        end else if (wr_ctrl) begin
            pol_ff <= wb_dat_i[asc_pkg::POLICY_BIT];
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // =========================================================
    // Assertions
    a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_latency: assert property (req && !$past(req) |-> ##2 wb_ack_o)
        else $error("ack not two cycles after request");
    a_ack_needs_req: assert property (wb_ack_o |-> req)
        else $error("ack without request");
    a_lock_rsvd_zero: assert property (
        wb_ack_o && !wb_we_i && idx == asc_pkg::LOCK_STAT_IDX
        |-> wb_dat_o[15:1] == 15'h0000) else $error("lock reserved set");
    a_aux_upper_zero: assert property (
        wb_ack_o && !wb_we_i && idx >= asc_pkg::AUX_BASE_IDX
        && idx < asc_pkg::AUX_BASE_IDX + 16'h0006
        |-> wb_dat_o[15:10] == 6'h00) else $error("aux upper bits set");
    a_wlen_follow: assert property (wr_ctrl
        |=> rx_word_len_sel == $past(wb_dat_i[1:0]))
        else $error("wlen wrong");
    a_wlen_stable: assert property ($changed(rx_word_len_sel)
        |-> $past(wr_ctrl)) else $error("wlen changed without write");
    a_strong_copy: assert property (
        !$past(pol_ff) && !wb_ack_o && $past(rst_n)
        |-> rx_frame_clk_out == $past(rx_frame_clk_in))
        else $error("frame clock not copied");
    a_weak_stop: assert property (
        $past(pol_ff) && !wb_ack_o && $past(rx_bad_smp_stb)
        |-> !rx_frame_clk_out)
        else $error("frame clock ran after loss");

    c_write: cover property (wr_ctrl);
    c_weak: cover property (pol_ff && $past(rx_bad_smp_stb));
    c_clk_out: cover property (rx_frame_clk_out);
endmodule : asc_ctrl_regs_props
`default_nettype wire

// *** dv/test_asc_ctrl_regs.sv ***
// Self-checking bench for the audio status and control register bank.
// Drives all ports directly; lock counts are shortened by parameter.
`timescale 1ns/1ps
`default_nettype none
module test_asc_ctrl_regs;
    localparam int NCNT = 4;
    localparam int QCNT = 2;
    localparam logic [15:0] CTRL = asc_pkg::RX_CTRL_IDX;
    localparam logic [15:0] LOCK = asc_pkg::LOCK_STAT_IDX;
    localparam logic [15:0] STAT = asc_pkg::IRQ_STAT_IDX;
    logic        clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0;
    logic        ack, a_stb = 0, a_frm = 0, good = 0, bad = 0;
    logic        fin = 0, fout, irq;
    logic [17:0] adr = '0;
    logic [3:0]  sel = '0;
    logic [31:0] dat = '0, dat_o, q;
    logic [31:0] seed = 32'h0f11_713d;
    logic [2:0]  a_ch = '0, r_sel = '0;
    logic [9:0]  a_code = '0;
    logic [15:0] r_val;
    logic [1:0]  wlen;
    logic [15:0] ratio_m [8];
    logic [9:0]  aux_m [6];
    logic [9:0]  pend_m [6];
    int          failures = 0;
    int          tests_run = 0;

    always #25 clk = ~clk;
    always @(posedge clk) fin <= ~fin;

    asc_ctrl_regs #(.NORMAL_CNT(NCNT), .QUICK_CNT(QCNT)) asc_ctrl_regs_i (
        .clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .aux_smp_stb(a_stb),
        .aux_smp_chan(a_ch), .aux_smp_code(a_code), .aux_frame_stb(a_frm),
        .rate_ratio_sel(r_sel), .rate_ratio_value(r_val),
        .rx_good_smp_stb(good), .rx_bad_smp_stb(bad),
        .rx_frame_clk_in(fin), .rx_frame_clk_out(fout),
        .rx_word_len_sel(wlen), .irq(irq));

    // =========================================================
    // Helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic summarize();
        $display("failures=%0d tests_run=%0d", failures, tests_run);
        if (failures == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Waits for ack as long as it takes; only the watchdog ends a hang
    task automatic bus(input logic w, input logic [15:0] i,
                       input logic [15:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= {i, 2'b00};
        dat <= {16'h0000, d};
        sel <= 4'h3;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        // Let a write that landed on the ack edge settle
        @(posedge clk);
    endtask : bus

    task automatic rd(input logic [15:0] i, input logic [15:0] e);
        bus(1'b0, i, 16'h0000);
        chk(q, {16'h0000, e});
    endtask : rd

    task automatic goods(input int n);
        repeat (n) begin
            @(posedge clk);
            good <= 1'b1;
        end
        @(posedge clk);
        good <= 1'b0;
    endtask : goods

    task automatic badp();
        @(posedge clk);
        bad <= 1'b1;
        @(posedge clk);
        bad <= 1'b0;
    endtask : badp

    task automatic aux_put(input logic [2:0] c, input logic [9:0] v);
        @(posedge clk);
        a_stb  <= 1'b1;
        a_ch   <= c;
        a_code <= v;
        @(posedge clk);
        a_stb  <= 1'b0;
    endtask : aux_put

    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        summarize();
    end

    // =========================================================
    // Main sequence
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            rd(asc_pkg::RATIO_BASE_IDX + 16'(i), 16'h0000);
            ratio_m[i] = 16'h0000;
        end
        for (int i = 0; i < 6; i++) begin
            rd(asc_pkg::AUX_BASE_IDX + 16'(i), 16'h0000);
            aux_m[i] = 10'h000;
        end
        rd(LOCK, 16'h0000);
        rd(CTRL, 16'h0000);
        rd(16'hF5A6, 16'h0000);
        bus(1'b1, 16'hF5A6, 16'h1234);
        rd(16'hF5A6, 16'h0000);
        // Random ratio words, read back and through the converter port
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            ratio_m[i] = seed[15:0];
            bus(1'b1, asc_pkg::RATIO_BASE_IDX + 16'(i), ratio_m[i]);
        end
        for (int i = 0; i < 8; i++) begin
            rd(asc_pkg::RATIO_BASE_IDX + 16'(i), ratio_m[i]);
            @(posedge clk);
            r_sel <= 3'(i);
            repeat (2) @(posedge clk);
            chk({16'h0000, r_val}, {16'h0000, ratio_m[i]});
        end
        // Channels 6 and 7 must be dropped
        for (int c = 0; c < 8; c++) begin
            seed = lfsr(seed);
            aux_put(3'(c), seed[9:0]);
            if (c < 6) pend_m[c] = seed[9:0];
        end
        for (int i = 0; i < 6; i++) begin
            rd(asc_pkg::AUX_BASE_IDX + 16'(i), {6'h00, aux_m[i]});
        end
        @(posedge clk);
        a_frm <= 1'b1;
        @(posedge clk);
        a_frm <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            aux_m[i] = pend_m[i];
            rd(asc_pkg::AUX_BASE_IDX + 16'(i), {6'h00, aux_m[i]});
        end
        bus(1'b1, asc_pkg::AUX_BASE_IDX, 16'hFFFF);
        rd(asc_pkg::AUX_BASE_IDX, 16'h03FF);
        for (int w = 0; w < 4; w++) begin
            bus(1'b1, CTRL, 16'(w));
            chk({30'h0, wlen}, 32'(w));
        end
        bus(1'b1, CTRL, 16'hFFF0);
        rd(CTRL, 16'h0000);
        // Lock with normal count, gain interrupt, clear, then loss
        bus(1'b1, asc_pkg::IRQ_MASK_IDX, 16'h0001);
        bus(1'b1, STAT, 16'h0007);
        goods(NCNT - 1);
        rd(LOCK, 16'h0000);
        goods(1);
        rd(LOCK, 16'h0001);
        rd(STAT, 16'h0001);
        chk({31'h0, irq}, 32'h1);
        bus(1'b1, STAT, 16'h0001);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        badp();
        rd(LOCK, 16'h0000);
        rd(STAT, 16'h0002);
        chk({31'h0, irq}, 32'h0);
        bus(1'b1, CTRL, 16'h0008);
        goods(QCNT);
        rd(LOCK, 16'h0001);
        // Weak policy: loss stops the frame clock
        bus(1'b1, CTRL, 16'h000C);
        badp();
        @(posedge clk);
        chk({31'h0, fout}, 32'h0);
        bus(1'b1, asc_pkg::IRQ_MASK_IDX, 16'h0002);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        bus(1'b1, STAT, 16'h0007);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        summarize();
    end
endmodule : test_asc_ctrl_regs

bind asc_ctrl_regs asc_ctrl_regs_props asc_ctrl_regs_props_i (
    .clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .rx_bad_smp_stb, .rx_frame_clk_in,
    .rx_frame_clk_out, .rx_word_len_sel);
`default_nettype wire

// *** hw/asc_ctrl_regs.sv ***
// Audio status and control register bank: rate ratio words, auxiliary
// converter results, receiver lock status and receiver control.
// Assumes a classic Wishbone master on clk; converter and receiver
// strobes are synchronous to clk.
// Writes land on the ack edge; read data is captured a cycle earlier.
`timescale 1ns/1ps
`default_nettype none
module asc_ctrl_regs #(
    parameter int NORMAL_CNT = asc_pkg::LOCK_CNT_NORMAL,
    parameter int QUICK_CNT  = asc_pkg::LOCK_CNT_QUICK
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [17:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Auxiliary converter
    input  wire logic        aux_smp_stb,
    input  wire logic [2:0]  aux_smp_chan,
    input  wire logic [9:0]  aux_smp_code,
    input  wire logic        aux_frame_stb,
    // Rate converter readback
    input  wire logic [2:0]  rate_ratio_sel,
    output logic      [15:0] rate_ratio_value,
    // Receiver
    input  wire logic        rx_good_smp_stb,
    input  wire logic        rx_bad_smp_stb,
    input  wire logic        rx_frame_clk_in,
    output logic             rx_frame_clk_out,
    output logic      [1:0]  rx_word_len_sel,
    // Interrupt
    output logic             irq
);

    localparam int W   = asc_pkg::REG_W;
    localparam int CW  = asc_pkg::AUX_CODE_W;
    localparam int IW  = asc_pkg::IRQ_W;

    // =========================================================
    // Address decode helpers
    function automatic logic in_span(input logic [15:0] idx,
                                     input logic [15:0] base,
                                     input int          cnt);
        in_span = (idx >= base) && (idx < base + 16'(cnt));
    endfunction : in_span

    function automatic logic [2:0] slot(input logic [15:0] idx,
                                        input logic [15:0] base);
        logic [15:0] d;
        d    = idx - base;
        slot = d[2:0];
    endfunction : slot

    // Single-word write strobe for words that live in byte lane 0
    function automatic logic wr_hit(input logic        go,
                                    input logic [15:0] at,
                                    input logic [15:0] target,
                                    input logic        lane);
        wr_hit = go && (at == target) && lane;
    endfunction : wr_hit

    // =========================================================
    // Bus slave state
    asc_pkg::asc_bus_t bus_ff;
    logic [15:0]       idx;
    logic              wr_go;
    logic              sel_ratio;
    logic              sel_aux;
    logic [2:0]        slot_ratio;
    logic [2:0]        slot_aux;
    logic [W-1:0]      wdata;
    logic [1:0]        be;

    assign idx        = wb_adr_i[17:2];
    assign wdata      = wb_dat_i[W-1:0];
    assign be         = wb_sel_i[1:0];
    assign sel_ratio  = in_span(idx, asc_pkg::RATIO_BASE_IDX,
                                asc_pkg::RATIO_COUNT);
    assign sel_aux    = in_span(idx, asc_pkg::AUX_BASE_IDX,
                                asc_pkg::AUX_COUNT);
    assign slot_ratio = slot(idx, asc_pkg::RATIO_BASE_IDX);
    assign slot_aux   = slot(idx, asc_pkg::AUX_BASE_IDX);
    // A write lands on the edge at which the master samples ack high
    assign wr_go      = (bus_ff == asc_pkg::ASC_ACK) && wb_cyc_i
                        && wb_stb_i && wb_we_i;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_ff <= asc_pkg::ASC_IDLE;
        end else begin
            unique case (bus_ff)
                asc_pkg::ASC_IDLE: begin
                    if (wb_cyc_i && wb_stb_i) begin
                        bus_ff <= asc_pkg::ASC_LOOK;
                    end
                end
                asc_pkg::ASC_LOOK: begin
                    // Master dropping the request early aborts it
                    bus_ff <= (wb_cyc_i && wb_stb_i) ? asc_pkg::ASC_ACK
                                                     : asc_pkg::ASC_IDLE;
                end
                asc_pkg::ASC_ACK: begin
                    // The master must drop the request after this ack
                    bus_ff <= asc_pkg::ASC_IDLE;
                end
                default: begin
                    bus_ff <= asc_pkg::ASC_IDLE;
                end
            endcase
        end
    end

    assign wb_ack_o = (bus_ff == asc_pkg::ASC_ACK);

    // =========================================================
    // Write strobes
    // Ratio and aux words honour both lanes; the rest use lane 0
    logic wr_ratio;
    logic wr_aux;
    logic wr_ctrl;
    logic wr_stat;
    logic wr_mask;

    assign wr_ratio = wr_go && sel_ratio;
    assign wr_aux   = wr_go && sel_aux;
    assign wr_ctrl  = wr_hit(wr_go, idx, asc_pkg::RX_CTRL_IDX, be[0]);
    assign wr_stat  = wr_hit(wr_go, idx, asc_pkg::IRQ_STAT_IDX, be[0]);
    assign wr_mask  = wr_hit(wr_go, idx, asc_pkg::IRQ_MASK_IDX, be[0]);

    // =========================================================
    // Rate ratio words
    logic [W-1:0] ratio_rd;

    // Converters read through their own port, off the bus path
    // eight 4.12 words
    asc_ratio_mem #(
        .DEPTH (asc_pkg::RATIO_COUNT),
        .WIDTH (W),
        .AW    (3)
    ) u_ratio (
        .clk     (clk),
        .rst_n   (rst_n),
        .wr_en   (wr_ratio),
        .wr_addr (slot_ratio),
        .wr_data (wdata),
        .wr_be   (be),
        .rd_addr (slot_ratio),
        .rd_data (ratio_rd),
        .cv_addr (rate_ratio_sel),
        .cv_data (rate_ratio_value)
    );

    // =========================================================
    // Auxiliary converter results
    logic [CW-1:0] aux_pend_ff [asc_pkg::AUX_COUNT];
    logic [CW-1:0] aux_res_ff  [asc_pkg::AUX_COUNT];

    // Samples gather during the frame so all six commit together
    // Codes for channels 6 and 7 have no slot and are dropped
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < asc_pkg::AUX_COUNT; i++) begin
                aux_pend_ff[i] <= '0;
            end
        end else if (aux_smp_stb
                     && (int'(aux_smp_chan) < asc_pkg::AUX_COUNT)) begin
            aux_pend_ff[aux_smp_chan] <= aux_smp_code;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < asc_pkg::AUX_COUNT; i++) begin
                aux_res_ff[i] <= '0;
            end
        end else if (aux_frame_stb) begin
            for (int i = 0; i < asc_pkg::AUX_COUNT; i++) begin
                aux_res_ff[i] <= aux_pend_ff[i];
            end
        end else if (wr_aux) begin
            // Writable, but the next frame overwrites it
            if (be[0]) begin
                aux_res_ff[slot_aux][7:0] <= wdata[7:0];
            end
            if (be[1]) begin
                aux_res_ff[slot_aux][CW-1:8] <= wdata[CW-1:8];
            end
        end
    end

    // =========================================================
    // Receiver control
    logic [asc_pkg::RX_CTRL_W-1:0] rx_ctrl_ff;
    logic                          quick_acquire_sel;
    logic                          unlock_output_policy;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_ctrl_ff <= asc_pkg::RX_CTRL_RESET;
        end else if (wr_ctrl) begin
            // Bits 15 to 4 have no storage, so they read zero
            rx_ctrl_ff <= wdata[asc_pkg::RX_CTRL_W-1:0];
        end
    end

    assign unlock_output_policy = rx_ctrl_ff[asc_pkg::POLICY_BIT];
    assign quick_acquire_sel    = rx_ctrl_ff[asc_pkg::QUICK_BIT];
    assign rx_word_len_sel =
        rx_ctrl_ff[asc_pkg::WLEN_LSB +: asc_pkg::WLEN_W];

    // =========================================================
    // Lock detection
    // No write path reaches the flag, so software cannot fake a lock
    logic lock_ff;
    logic lock_gain;
    logic lock_loss;

    asc_lock_det #(
        .NORMAL_CNT (NORMAL_CNT),
        .QUICK_CNT  (QUICK_CNT)
    ) u_lock (
        .clk                  (clk),
        .rst_n                (rst_n),
        .quick_acquire_sel    (quick_acquire_sel),
        .unlock_output_policy (unlock_output_policy),
        .good_smp_stb         (rx_good_smp_stb),
        .bad_smp_stb          (rx_bad_smp_stb),
        .frame_clk_in         (rx_frame_clk_in),
        .lock_ff              (lock_ff),
        .lock_gain            (lock_gain),
        .lock_loss            (lock_loss),
        .frame_clk_out        (rx_frame_clk_out)
    );

    // =========================================================
    // Interrupt status and mask
    logic [IW-1:0] irq_stat_ff;
    logic [IW-1:0] irq_mask_ff;
    logic [IW-1:0] irq_set;
    logic [IW-1:0] irq_clr;

    always_comb begin
        irq_set = '0;
        irq_set[asc_pkg::IRQ_LOCK_GAIN] = lock_gain;
        irq_set[asc_pkg::IRQ_LOCK_LOSS] = lock_loss;
        irq_set[asc_pkg::IRQ_AUX_FRAME] = aux_frame_stb;
        irq_clr = '0;
        if (wr_stat) begin
            irq_clr = wdata[IW-1:0];
        end
    end

    // Set beats a clear in the same cycle so no event is lost
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat_ff <= asc_pkg::IRQ_RESET;
        end else begin
            irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_mask_ff <= asc_pkg::IRQ_RESET;
        end else if (wr_mask) begin
            irq_mask_ff <= wdata[IW-1:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            // Registered so the pin is glitch-free; it trails status a cycle
            irq <= |(irq_stat_ff & irq_mask_ff);
        end
    end

    // =========================================================
    // Read data
    logic [W-1:0] rd_local;

    always_comb begin
        rd_local = asc_pkg::REG_RESET;
        // Unmapped indices read zero; writes to them are dropped
        if (sel_ratio) begin
            rd_local = ratio_rd;
        end else if (sel_aux) begin
            rd_local[CW-1:0] = aux_res_ff[slot_aux];
        end else if (idx == asc_pkg::LOCK_STAT_IDX) begin
            rd_local[asc_pkg::LOCK_BIT] = lock_ff;
        end else if (idx == asc_pkg::RX_CTRL_IDX) begin
            rd_local[asc_pkg::RX_CTRL_W-1:0] = rx_ctrl_ff;
        end else if (idx == asc_pkg::IRQ_STAT_IDX) begin
            rd_local[IW-1:0] = irq_stat_ff;
        end else if (idx == asc_pkg::IRQ_MASK_IDX) begin
            rd_local[IW-1:0] = irq_mask_ff;
        end
    end

    // Ratio memory data is ready in LOOK, so capture there
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_dat_o <= '0;
        end else if (bus_ff == asc_pkg::ASC_LOOK) begin
            wb_dat_o <= {16'h0000, rd_local};
        end
    end

endmodule : asc_ctrl_regs
`default_nettype wire

// *** hw/asc_lock_det.sv ***
// Receiver lock detector and recovered frame clock gate.
// Assumes sample strobes come from receiver logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module asc_lock_det #(
    parameter int NORMAL_CNT = asc_pkg::LOCK_CNT_NORMAL,
    parameter int QUICK_CNT  = asc_pkg::LOCK_CNT_QUICK
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Settings
    input  wire logic quick_acquire_sel,
    input  wire logic unlock_output_policy,
    // Receiver strobes
    input  wire logic good_smp_stb,
    input  wire logic bad_smp_stb,
    input  wire logic frame_clk_in,
    // Results
    output logic      lock_ff,
    output logic      lock_gain,
    output logic      lock_loss,
    output logic      frame_clk_out
);

    localparam int CW = asc_pkg::LOCK_CNT_W;
    logic [CW-1:0] run_ff;
    logic [CW-1:0] need;

    always_comb begin
        need = quick_acquire_sel ? CW'(QUICK_CNT) : CW'(NORMAL_CNT);
    end

    // =========================================================
    // Consecutive valid sample count and lock flag
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            run_ff  <= '0;
            lock_ff <= 1'b0;
        end else if (bad_smp_stb) begin
            run_ff  <= '0;
            lock_ff <= 1'b0;
        end else if (good_smp_stb && !lock_ff) begin
            if (run_ff + CW'(1) >= need) begin
                lock_ff <= 1'b1;
                run_ff  <= '0;
            end else begin
                run_ff <= run_ff + CW'(1);
            end
        end
    end

    assign lock_gain = good_smp_stb && !bad_smp_stb && !lock_ff
                       && (run_ff + CW'(1) >= need);
    assign lock_loss = bad_smp_stb && lock_ff;

    // =========================================================
    // Frame clock gate
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_clk_out <= 1'b0;
        end else if (unlock_output_policy) begin
            frame_clk_out <= frame_clk_in && lock_ff && !bad_smp_stb;
        end else begin
            frame_clk_out <= frame_clk_in;
        end
    end

endmodule : asc_lock_det
`default_nettype wire

// *** hw/asc_pkg.sv ***
// Package for the audio status and control register bank.
// Assumes a 32-bit classic Wishbone slave; register indices are word
// indices, byte address is four times the index.
package asc_pkg;

    // =========================================================
    // Register indices
    localparam logic [15:0] RATIO_BASE_IDX   = 16'hF582;
    localparam logic [15:0] AUX_BASE_IDX     = 16'hF5A0;
    localparam logic [15:0] LOCK_STAT_IDX    = 16'hF600;
    localparam logic [15:0] RX_CTRL_IDX      = 16'hF601;
    localparam logic [15:0] IRQ_STAT_IDX     = 16'hF610;
    localparam logic [15:0] IRQ_MASK_IDX     = 16'hF611;
    localparam int          RATIO_COUNT      = 8;
    localparam int          AUX_COUNT        = 6;

    // =========================================================
    // Field layouts and widths
    localparam int          REG_W            = 16;
    localparam int          AUX_CODE_W       = 10;
    localparam int          RATIO_INT_W      = 4;
    localparam int          RATIO_FRAC_W     = 12;
    localparam int          LOCK_BIT         = 0;
    localparam int          QUICK_BIT        = 3;
    localparam int          POLICY_BIT       = 2;
    localparam int          WLEN_LSB         = 0;
    localparam int          WLEN_W           = 2;
    localparam int          RX_CTRL_W        = 4;
    localparam int          IRQ_W            = 3;
    localparam int          IRQ_LOCK_GAIN    = 0;
    localparam int          IRQ_LOCK_LOSS    = 1;
    localparam int          IRQ_AUX_FRAME    = 2;

    // =========================================================
    // Reset values
    localparam logic [15:0] REG_RESET        = 16'h0000;
    localparam logic [3:0]  RX_CTRL_RESET    = 4'h0;
    localparam logic [2:0]  IRQ_RESET        = 3'h0;

    // =========================================================
    // Lock acquisition counts
    localparam int          LOCK_CNT_NORMAL  = 64;
    localparam int          LOCK_CNT_QUICK   = 8;
    localparam int          LOCK_CNT_W       = 7;

    // =========================================================
    // Word length codes
    typedef enum logic [1:0] {
        ASC_WLEN_24   = 2'h0,
        ASC_WLEN_20   = 2'h1,
        ASC_WLEN_16   = 2'h2,
        ASC_WLEN_AUTO = 2'h3
    } asc_wlen_t;

    // Bus slave phases
    typedef enum logic [2:0] {
        ASC_IDLE = 3'b001,
        ASC_LOOK = 3'b010,
        ASC_ACK  = 3'b100
    } asc_bus_t;

endpackage : asc_pkg

// *** hw/asc_ratio_mem.sv ***
// Small register memory holding the rate ratio words.
// One write port and two read ports whose data come from flip-flops.
`timescale 1ns/1ps
`default_nettype none
module asc_ratio_mem #(
    parameter int DEPTH = 8,
    parameter int WIDTH = 16,
    parameter int AW    = 3
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Write port with byte enables
    input  wire logic             wr_en,
    input  wire logic [AW-1:0]    wr_addr,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic [1:0]       wr_be,
    // Bus read port
    input  wire logic [AW-1:0]    rd_addr,
    output logic      [WIDTH-1:0] rd_data,
    // Converter read port
    input  wire logic [AW-1:0]    cv_addr,
    output logic      [WIDTH-1:0] cv_data
);

    logic [WIDTH-1:0] mem_ff [DEPTH];

    // =========================================================
    // Storage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_ff[i] <= asc_pkg::REG_RESET;
            end
        end else if (wr_en) begin
            if (wr_be[0]) begin
                mem_ff[wr_addr][7:0] <= wr_data[7:0];
            end
            if (wr_be[1]) begin
                mem_ff[wr_addr][WIDTH-1:8] <= wr_data[WIDTH-1:8];
            end
        end
    end

    // =========================================================
    // Registered reads
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= asc_pkg::REG_RESET;
            cv_data <= asc_pkg::REG_RESET;
        end else begin
            rd_data <= mem_ff[rd_addr];
            cv_data <= mem_ff[cv_addr];
        end
    end

endmodule : asc_ratio_mem
`default_nettype wire
